// >>> port3_pkg.sv
// constants and carriers for the port three data register block
// Operation
// - eight-bit register: upper nibble outputs, lower inputs
// - pin seven follows bit unless comparator-output enabled
// - timer-one field 01 gives pin six to timers
// - timer-two bit zero gives pin five timer
// - pin four: comparator or timer override blocks writes
// - programming mode blocks writes reaching pin four
// - upper nibble reads last written value
// - writes to lower nibble ignored
// - bit three: pin or stop-recovery condition, inverted
// - bit two: pin or comparator two output
// - bit one: pin, comparator one, or amplifier
// - reset clears outputs; stop recovery keeps contents
// - amplifier bit overrides analog bit for bit one
package port3_pkg;
  localparam logic [7:0] port_three_data_off = 8'h03;
  localparam logic [3:0] out_rst_val         = 4'h0;
  localparam int         sync_stages         = 3;
  localparam logic [1:0] t1_timer_out_mode   = 2'h1;

  // mode and control bits taken from the neighbouring registers
  typedef struct packed {
    logic       amp_enable;     // port_three_mode bit 2
    logic       analog_mode;    // port_three_mode bit 1
    logic       cmp_out_en;     // port_config_reg bit 0
    logic [1:0] t1_mode;        // timer_one_control bits 7:6
    logic       t2_out_en;      // timer_two_control bit 0
    logic       t0_out_en;      // timer_zero_control bit 0
    logic       stop_recovery_control_four_sel;       // stop_recovery_control_four bit 4
    logic       icp_mode;       // in_circuit_programming active
  } port3_ctrl_t;

  // alternate-function sources
  typedef struct packed {
    logic cmp1_out;
    logic cmp2_out;
    logic ir_amp_out;
    logic t8_t16_out;
    logic t16_out;
    logic t8_out;
    logic smr_cond;
  } port3_func_t;
endpackage

// >>> port3_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module port3_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // pin
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic [port3_pkg::sync_stages-1:0] stage_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[port3_pkg::sync_stages-2:0], pin_in};
    end
  end

  // level taken once second and third stages agree
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_sync <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      pin_sync <= stage_r[2];
    end
  end
endmodule // port3_sync

// >>> port3_mixed_io.sv
// port three mixed input/output data register
`timescale 1ns/1ps
module port3_mixed_io (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // mode and alternate functions
  input  wire port3_pkg::port3_ctrl_t ctrl,
  input  wire port3_pkg::port3_func_t func,
  // pins
  input  wire logic [3:0]         pin_in,
  output logic      [7:4]         pin_out
);
  logic [3:0] out_r;
  logic [3:0] in_sync;
  logic [7:0] read_val;
  logic       hit;

  function automatic logic addr_hit(input logic [7:0] a);
    return a == port3_pkg::port_three_data_off;
  endfunction

  assign hit = addr_hit(reg_addr);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      port3_sync u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .pin_in   (pin_in[g]),
        .pin_sync (in_sync[g])
      );
    end
  endgenerate

  // only upper nibble stored; stop recovery is not a reset here
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_r <= port3_pkg::out_rst_val;
    end else if (reg_wr && hit) begin
      out_r <= reg_wdata[7:4];
    end
  end

  // pin drive with function overrides
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_out <= port3_pkg::out_rst_val;
    end else begin
      pin_out[7] <= ctrl.cmp_out_en ? func.cmp1_out : out_r[3];
      pin_out[6] <= (ctrl.t1_mode == port3_pkg::t1_timer_out_mode) ?
                    func.t8_t16_out : out_r[2];
      pin_out[5] <= ctrl.t2_out_en ? func.t16_out : out_r[1];
      if (ctrl.icp_mode) begin
        pin_out[4] <= pin_out[4];
      end else if (ctrl.cmp_out_en) begin
        pin_out[4] <= func.cmp2_out;
      end else if (ctrl.t0_out_en) begin
        pin_out[4] <= func.t8_out;
      end else begin
        pin_out[4] <= out_r[0];
      end
    end
  end

  always_comb begin
    read_val[7:4] = out_r;
    if (ctrl.analog_mode || ctrl.stop_recovery_control_four_sel) begin
      read_val[3] = ~func.smr_cond;
    end else begin
      read_val[3] = in_sync[3];
    end
    read_val[2] = ctrl.analog_mode ? func.cmp2_out : in_sync[2];
    if (ctrl.amp_enable) begin
      read_val[1] = func.ir_amp_out;
    end else if (ctrl.analog_mode) begin
      read_val[1] = func.cmp1_out;
    end else begin
      read_val[1] = in_sync[1];
    end
    read_val[0] = ctrl.analog_mode ? 1'b1 : in_sync[0];
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && hit) begin
      reg_rdata <= read_val;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // port3_mixed_io

// >>> port3_chk.sv
// assertion checker for the port three data register block
`timescale 1ns/1ps
module port3_chk (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   sys_rst,
  // register port
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic [7:0]             reg_rdata,
  // modes, functions and pin drive
  input wire port3_pkg::port3_ctrl_t ctrl,
  input wire port3_pkg::port3_func_t func,
  input wire logic [7:4]             pin_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic run_r;
  wire  rd3 = reg_rd && reg_addr == port3_pkg::port_three_data_off;
  always_ff @(posedge clock) run_r <= !sys_rst;
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst |=> pin_out == 4'h0)
    else $error("pin drive not cleared");
  chk_bad_addr: assert property (reg_rd && reg_addr != 8'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_read_back: assert property (reg_wr && reg_addr == 8'h03 ##1 rd3
    |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 2)) else $error("readback wrong");
  chk_pin_seven: assert property (run_r && $past(ctrl.cmp_out_en)
    |-> pin_out[7] == $past(func.cmp1_out)) else $error("pin seven wrong");
  chk_pin_six: assert property (run_r && $past(ctrl.t1_mode) == 2'h1
    |-> pin_out[6] == $past(func.t8_t16_out)) else $error("pin six wrong");
  chk_pin_five: assert property (run_r && $past(ctrl.t2_out_en)
    |-> pin_out[5] == $past(func.t16_out)) else $error("pin five wrong");
  chk_bit_zero: assert property (rd3 && ctrl.analog_mode |=> reg_rdata[0] == 1'b1)
    else $error("bit zero not one");
  chk_pin_four: assert property (run_r && $past(ctrl.cmp_out_en && !ctrl.icp_mode)
    |-> pin_out[4] == $past(func.cmp2_out)) else $error("pin four wrong");
  chk_icp_hold: assert property (run_r && $past(ctrl.icp_mode) |-> $stable(pin_out[4]))
    else $error("pin four moved");
  chk_smr_bit: assert property (rd3 && (ctrl.analog_mode || ctrl.stop_recovery_control_four_sel)
    |=> reg_rdata[3] == !$past(func.smr_cond)) else $error("bit three wrong");
endmodule // port3_chk
bind port3_mixed_io port3_chk port3_chk_i (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .ctrl, .func, .pin_out);

// >>> tb.sv
// self-checking bench for the port three data register block
`timescale 1ns/1ps
module tb;
  logic                   clock, sys_rst, reg_wr, reg_rd;
  logic [7:0]             reg_addr, reg_wdata, reg_rdata;
  logic [3:0]             pin_in;
  logic [7:4]             pin_out;
  port3_pkg::port3_ctrl_t ctrl;
  port3_pkg::port3_func_t func;
  int                     err_total, n_checks, cyc;
  port3_mixed_io port3_mixed_io_i (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ctrl, .func, .pin_in, .pin_out);
  task automatic close_out;
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // called right after a rising edge; returns at the edge that takes the write
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe: compared at the edge ending it
  task automatic rd(input logic [7:0] a, e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, e);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 200) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 16'h0};
    ctrl = '0;
    func = '0;
    pin_in = 4'ha;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    chk({pin_out, 4'h0}, 8'h00);
    rd(8'h03, 8'h0a);
    wr(8'h03, 8'h5f);
    rd(8'h03, 8'h5a);
    chk({pin_out, 4'h0}, 8'h50);
    rd(8'h04, 8'h00);
    // all pin overrides but timer zero on, amplifier and analog mode set
    func <= 7'h5a;
    ctrl <= 9'h1d8;
    wr(8'h03, 8'h30);
    rd(8'h03, 8'h3b);
    chk({pin_out, 4'h0}, 8'hc0);
    // programming mode freezes pin four while comparator two rises
    ctrl <= 9'h1d9;
    func <= 7'h7b;
    repeat (3) @(posedge clock);
    chk({pin_out, 4'h0}, 8'hc0);
    rd(8'h03, 8'h37);
    // timer-zero drive on pin four, stop-recovery select, new pin levels
    ctrl <= 9'h006;
    func <= 7'h03;
    pin_in <= 4'h5;
    repeat (4) @(posedge clock);
    wr(8'h03, 8'ha0);
    rd(8'h03, 8'ha5);
    chk({pin_out, 4'h0}, 8'hb0);
    // analog mode alone: bit one shows comparator one
    ctrl <= 9'h080;
    func <= 7'h40;
    rd(8'h03, 8'hab);
    // reset in mid-run clears the stored nibble and the pin drive
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(8'h03, 8'h0b);
    chk({pin_out, 4'h0}, 8'h00);
    close_out();
  end
endmodule // tb
